/* psr_periph_model.sv */
// peripheral side model: one flag per unit, set while its reset line is high
module psr_periph_model (
  // clock
  input wire logic clock,
  // reset lines from the control block
  input wire logic [19:0] reset_lines,
  // units currently held in reset
  output logic [19:0] held_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  // a unit stays idle for as long as its line is high, one flop of delay
  always_ff @(posedge clock) begin
    held_ff <= reset_lines;
  end
endmodule

/* psr_pkg.sv */
// constants shared by the peripheral software reset control block
// Contract
// - low register writes masked by capability one
// - high register writes masked by capability two
// - low bit 20 resets pwm module
// - low bit 16 resets converter 0
// - low bit 6 resets hibernation module
// - low bit 3 resets watchdog unit
// - reserved bits read zero, writes ignored
// - both registers reset to all zeros
// - high low-half bits reset serial, two-wire, decoder units
package psr_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // register byte offsets
  localparam logic [11:0] LOW_OFFSET = 12'h040;
  localparam logic [11:0] HIGH_OFFSET = 12'h044;

  // reset value of both registers
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // implemented field bits; everything else is reserved
  localparam logic [31:0] LOW_FIELD_MASK = 32'h0011_0048;
  localparam logic [31:0] HIGH_FIELD_MASK = 32'h070F_5337;

  // field positions, low register
  localparam int unsigned PWM_POS = 20;
  localparam int unsigned CONVERTER0_POS = 16;
  localparam int unsigned HIBERNATION_POS = 6;
  localparam int unsigned WATCHDOG_POS = 3;

  // field positions, high register
  localparam int unsigned COMPARATOR0_POS = 24;
  localparam int unsigned COMPARATOR_NUM = 3;
  localparam int unsigned GP_COUNTER0_POS = 16;
  localparam int unsigned GP_COUNTER_NUM = 4;
  localparam int unsigned TWO_WIRE1_POS = 14;
  localparam int unsigned TWO_WIRE0_POS = 12;
  localparam int unsigned QUAD_DECODER0_POS = 8;
  localparam int unsigned QUAD_DECODER_NUM = 2;
  localparam int unsigned SYNC_SERIAL0_POS = 4;
  localparam int unsigned SYNC_SERIAL_NUM = 2;
  localparam int unsigned ASYNC_SERIAL0_POS = 0;
  localparam int unsigned ASYNC_SERIAL_NUM = 3;

  // response codes
  typedef logic [1:0] psr_resp_type;
  localparam psr_resp_type RESP_OKAY = 2'h0;
  localparam psr_resp_type RESP_SLVERR = 2'h2;

endpackage

/* psr_reg_if.sv */
// carrier between the bus front end, a reset register and its output stage
interface psr_reg_if;
  logic wr_stb; // one-cycle write pulse
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // byte enables
  logic [31:0] cap_mask; // capability mask for this register
  logic [31:0] value; // current register contents

  // bus front end side
  modport ctrl (output wr_stb, output wr_data, output wr_strb, output cap_mask,
                input value);
  // register side
  modport regs (input wr_stb, input wr_data, input wr_strb, input cap_mask,
                output value);
  // output stage side
  modport watch (input value);
endinterface

/* psr_reset_ctrl.sv */
// top of the peripheral software reset control block with axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module psr_reset_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // capability masks, same clock domain
  input wire logic [31:0] capability_mask_one,
  input wire logic [31:0] capability_mask_two,
  // resets from the low register
  output logic pwm_reset,
  output logic converter0_reset,
  output logic hibernation_reset,
  output logic watchdog_reset,
  // resets from the high register
  output logic [2:0] comparator_reset,
  output logic [3:0] gp_counter_reset,
  output logic [1:0] two_wire_reset,
  output logic [1:0] quad_decoder_reset,
  output logic [1:0] sync_serial_reset,
  output logic [2:0] async_serial_reset
);

  // a thin slave: two storage registers, two output stages
  // and the channel bookkeeping around them
  // the capability masks come from logic on this clock, so the
  // whole block is one domain and needs no synchroniser
  // register carriers
  psr_reg_if low_bus ();
  psr_reg_if high_bus ();

  // held copies let address and data land on different edges;
  // the master may offer either channel first
  // write address holding
  logic aw_held_ff; // address taken, write not yet done
  logic [11:0] aw_addr_ff; // held write address

  // write data holding
  logic w_held_ff; // data taken, write not yet done
  logic [31:0] w_data_ff; // held write data
  logic [3:0] w_strb_ff; // held byte enables

  // write response
  logic bvalid_ff; // response pending
  logic [1:0] bresp_ff; // response code

  // read channel
  logic rvalid_ff; // read data pending
  logic [31:0] rdata_ff; // read data
  logic [1:0] rresp_ff; // read response code

  // combined handshake terms
  logic aw_take; // address moves this edge
  logic w_take; // data moves this edge
  logic ar_take; // read address moves this edge
  logic have_aw; // address available for the write
  logic have_w; // data available for the write
  logic do_write; // both halves present, write happens now

  // selected write payload, held copy or live bus
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // address decode
  logic wr_hit_low; // write targets the low register
  logic wr_hit_high; // write targets the high register
  logic wr_hit; // write targets any register
  logic rd_hit_low; // read targets the low register
  logic rd_hit_high; // read targets the high register
  logic [31:0] nxt_rdata; // read mux result
  logic [1:0] nxt_rresp; // read response result

  // flopped reset lines from the output stages
  logic [31:0] low_lines;
  logic [31:0] high_lines;

  // ready terms; a channel stalls while its half is held or
  // a response is still waiting, so one write at a time
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  // one read at a time; no new address while data waits
  assign s_axi_arready = !rvalid_ff;
  // readies stay low for as long as bvalid stands, so a second
  // write cannot slip in behind an unanswered first one

  // handshake detection
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // a write fires once both halves are in, in either order
  assign have_aw = aw_held_ff || aw_take;
  assign have_w = w_held_ff || w_take;
  assign do_write = have_aw && have_w;
  // both halves on one edge costs no extra cycle; a split
  // write simply waits in the held copies

  // payload selection: held copy wins over the live bus
  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;

  // write decode on word address; the two low address bits are ignored
  assign wr_hit_low = (wr_addr[11:2] == psr_pkg::LOW_OFFSET[11:2]);
  assign wr_hit_high = (wr_addr[11:2] == psr_pkg::HIGH_OFFSET[11:2]);
  assign wr_hit = wr_hit_low || wr_hit_high;
  // a miss still completes the handshake, only the code differs;
  // a stalled bus would hurt more than a dropped write

  // read decode on word address
  assign rd_hit_low = (s_axi_araddr[11:2] == psr_pkg::LOW_OFFSET[11:2]);
  assign rd_hit_high = (s_axi_araddr[11:2] == psr_pkg::HIGH_OFFSET[11:2]);

  // low register access
  assign low_bus.wr_stb = do_write && wr_hit_low;
  assign low_bus.wr_data = wr_data;
  assign low_bus.wr_strb = wr_strb;
  // absent units in the low register are locked out
  assign low_bus.cap_mask = capability_mask_one;

  // high register access
  assign high_bus.wr_stb = do_write && wr_hit_high;
  assign high_bus.wr_data = wr_data;
  assign high_bus.wr_strb = wr_strb;
  // absent units in the high register are locked out
  assign high_bus.cap_mask = capability_mask_two;

  // each register masks its own writes; the bus side only picks
  // which one is strobed and never sees reserved bits
  // low register storage
  psr_reset_reg #(
    .FIELD_MASK(psr_pkg::LOW_FIELD_MASK)
  ) u_low_reg (
    .clock(clock),
    .reset(reset),
    .bus(low_bus)
  );

  // high register storage
  psr_reset_reg #(
    .FIELD_MASK(psr_pkg::HIGH_FIELD_MASK)
  ) u_high_reg (
    .clock(clock),
    .reset(reset),
    .bus(high_bus)
  );

  // output stages cost one clock of lag but keep decode
  // glitches off the peripheral reset nets
  // low register output stage
  psr_reset_drive u_low_drive (
    .clock(clock),
    .reset(reset),
    .bus(low_bus),
    .lines(low_lines)
  );

  // high register output stage
  psr_reset_drive u_high_drive (
    .clock(clock),
    .reset(reset),
    .bus(high_bus),
    .lines(high_lines)
  );

  // write address hold: kept only while data has not yet arrived
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_ff <= 1'b0;
    end else if (do_write) begin
      // write done, nothing left to hold
      aw_held_ff <= 1'b0;
    end else if (aw_take) begin
      // address alone, wait for data
      aw_held_ff <= 1'b1;
    end
  end

  // address copy refreshed on every take, used only when held
  // write address capture
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_addr_ff <= 12'h000;
    end else if (aw_take) begin
      aw_addr_ff <= s_axi_awaddr;
    end
  end

  // write data hold: kept only while the address has not yet arrived
  always_ff @(posedge clock) begin
    if (reset) begin
      w_held_ff <= 1'b0;
    end else if (do_write) begin
      // write done, nothing left to hold
      w_held_ff <= 1'b0;
    end else if (w_take) begin
      // data alone, wait for address
      w_held_ff <= 1'b1;
    end
  end

  // data and byte enables are kept together, never split
  // write data capture
  always_ff @(posedge clock) begin
    if (reset) begin
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (w_take) begin
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end
  end

  // a response left waiting blocks both write channels
  // write response; raised the edge the write is done
  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
    end else if (do_write) begin
      // do_write cannot happen while bvalid is up, readies are low
      bvalid_ff <= 1'b1;
    end else if (s_axi_bready) begin
      // response accepted by the master
      bvalid_ff <= 1'b0;
    end
  end

  // write response code; an unmapped write changes nothing
  always_ff @(posedge clock) begin
    if (reset) begin
      bresp_ff <= psr_pkg::RESP_OKAY;
    end else if (do_write) begin
      if (wr_hit) begin
        bresp_ff <= psr_pkg::RESP_OKAY;
      end else begin
        bresp_ff <= psr_pkg::RESP_SLVERR;
      end
    end
  end

  // the mux sees stored contents, so a read taken on the edge of
  // a write returns the old value
  // read mux; reserved bits never get stored, so they read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = psr_pkg::RESP_OKAY;
    if (rd_hit_low) begin
      nxt_rdata = low_bus.value & psr_pkg::LOW_FIELD_MASK;
    end else if (rd_hit_high) begin
      nxt_rdata = high_bus.value & psr_pkg::HIGH_FIELD_MASK;
    end else begin
      // unmapped: zero data with an error code
      nxt_rresp = psr_pkg::RESP_SLVERR;
    end
  end

  // reads never wait on writes; the paths share only storage
  // read valid; data follows one edge after the address
  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
    end else if (s_axi_rready) begin
      // data accepted by the master
      rvalid_ff <= 1'b0;
    end
  end

  // read data capture; stays put until the next read is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff <= psr_pkg::RESET_VALUE;
      rresp_ff <= psr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // every response signal below comes straight from a flop
  // bus outputs
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // positions come from the package; a moved field changes
  // here without touching storage or bus logic
  // low register fan-out; a line stays high while its bit is set
  assign pwm_reset = low_lines[psr_pkg::PWM_POS];
  assign converter0_reset = low_lines[psr_pkg::CONVERTER0_POS];
  assign hibernation_reset = low_lines[psr_pkg::HIBERNATION_POS];
  assign watchdog_reset = low_lines[psr_pkg::WATCHDOG_POS];

  // comparators 2..0 from the top field
  assign comparator_reset =
    high_lines[psr_pkg::COMPARATOR0_POS +: psr_pkg::COMPARATOR_NUM];

  // general-purpose counters 3..0
  assign gp_counter_reset =
    high_lines[psr_pkg::GP_COUNTER0_POS +: psr_pkg::GP_COUNTER_NUM];

  // two-wire units sit on non-adjacent bits
  assign two_wire_reset = {high_lines[psr_pkg::TWO_WIRE1_POS],
                           high_lines[psr_pkg::TWO_WIRE0_POS]};

  // quadrature decoders 1..0
  assign quad_decoder_reset =
    high_lines[psr_pkg::QUAD_DECODER0_POS +: psr_pkg::QUAD_DECODER_NUM];

  // synchronous serial units 1..0
  assign sync_serial_reset =
    high_lines[psr_pkg::SYNC_SERIAL0_POS +: psr_pkg::SYNC_SERIAL_NUM];

  // asynchronous serial units 2..0
  assign async_serial_reset =
    high_lines[psr_pkg::ASYNC_SERIAL0_POS +: psr_pkg::ASYNC_SERIAL_NUM];

  // high bits 31:27, 23:20, 15, 13, 11:10, 7:6 and 3 reach no pin;
  // their storage is masked to zero and trims away
endmodule

/* psr_reset_ctrl_checker.sv */
// concurrent checks on the ports of the software reset control top
module psr_reset_ctrl_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // capability masks
  input wire logic [31:0] capability_mask_one,
  input wire logic [31:0] capability_mask_two,
  // peripheral reset lines
  input wire logic pwm_reset,
  input wire logic converter0_reset,
  input wire logic hibernation_reset,
  input wire logic watchdog_reset,
  input wire logic [2:0] comparator_reset,
  input wire logic [3:0] gp_counter_reset,
  input wire logic [1:0] two_wire_reset,
  input wire logic [1:0] quad_decoder_reset,
  input wire logic [1:0] sync_serial_reset,
  input wire logic [2:0] async_serial_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] rd_addr_ff; // address of the read in flight
  logic rd_low; // read targets the low register
  logic rd_high; // read targets the high register
  logic [19:0] lines; // all reset lines in one vector
  assign rd_low = (rd_addr_ff[11:2] == 10'h010);
  assign rd_high = (rd_addr_ff[11:2] == 10'h011);
  assign lines = {pwm_reset, converter0_reset, hibernation_reset, watchdog_reset, comparator_reset,
                  gp_counter_reset, two_wire_reset, quad_decoder_reset, sync_serial_reset,
                  async_serial_reset};
  // keep the accepted read address, so the answer can be decoded
  always_ff @(posedge clock) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_ff <= s_axi_araddr;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_low_cap_mask: assert property ($rose(pwm_reset) |-> $past(capability_mask_one[20], 2))
    else $error("pwm line rose without its capability bit");
  chk_high_cap_mask: assert property ($rose(comparator_reset[0]) |->
    $past(capability_mask_two[24], 2)) else $error("comparator line rose without capability");
  chk_reserved_low: assert property (s_axi_rvalid && rd_low |->
    (s_axi_rdata & ~psr_pkg::LOW_FIELD_MASK) == 32'h0) else $error("low reserved bits not zero");
  chk_reserved_high: assert property (s_axi_rvalid && rd_high |->
    (s_axi_rdata & ~psr_pkg::HIGH_FIELD_MASK) == 32'h0) else $error("high reserved bits not zero");
  chk_reset_clear: assert property ($fell(reset) |->
    lines == 20'h0 && !s_axi_bvalid && !s_axi_rvalid) else $error("state left after reset");
  chk_lines_after_write: assert property ($changed(lines) |-> $past(s_axi_bvalid))
    else $error("reset line moved without a write");
  chk_unmapped_read: assert property (s_axi_rvalid && !rd_low && !rd_high |->
    s_axi_rresp == psr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp) && !s_axi_awready) else $error("write answer dropped");
endmodule

bind psr_reset_ctrl psr_reset_ctrl_checker psr_reset_ctrl_checker_inst (
  .clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .capability_mask_one, .capability_mask_two,
  .pwm_reset, .converter0_reset, .hibernation_reset, .watchdog_reset, .comparator_reset,
  .gp_counter_reset, .two_wire_reset, .quad_decoder_reset, .sync_serial_reset, .async_serial_reset
);

/* psr_reset_ctrl_test.sv */
// self-checking bench for the peripheral software reset control block
module psr_reset_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: a write, then a read back of the same address
  typedef struct {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [31:0] cap;
    logic [1:0] resp;
    logic [31:0] rd;
  } psr_row_type;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [31:0] capability_mask_one = 32'hFFFF_FFFF, capability_mask_two = 32'hFFFF_FFFF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_data, lo_exp, hi_exp;
  logic pwm_reset, converter0_reset, hibernation_reset, watchdog_reset;
  logic [2:0] comparator_reset, async_serial_reset;
  logic [3:0] gp_counter_reset;
  logic [1:0] two_wire_reset, quad_decoder_reset, sync_serial_reset;
  logic [19:0] lines, held_ff;
  int n_mismatch = 0, samples_checked = 0;
  // later rows build on what earlier rows left in the registers
  psr_row_type rows [9] = '{
    '{12'h040, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, 2'h0, 32'h0011_0048},
    '{12'h040, 32'h0000_0000, 4'hF, 32'hFFEF_FFFF, 2'h0, 32'h0010_0000},
    '{12'h040, 32'h0000_0000, 4'hF, 32'hFFFF_FFFF, 2'h0, 32'h0000_0000},
    '{12'h040, 32'hFFFF_FFFF, 4'hF, 32'h0001_0000, 2'h0, 32'h0001_0000},
    '{12'h044, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, 2'h0, 32'h070F_5337},
    '{12'h044, 32'h0000_0000, 4'h3, 32'hFFFF_FFFF, 2'h0, 32'h070F_0000},
    '{12'h044, 32'h0000_0000, 4'hF, 32'hFEFF_FFFF, 2'h0, 32'h0100_0000},
    '{12'h044, 32'h0000_0000, 4'hF, 32'hFFFF_FFFF, 2'h0, 32'h0000_0000},
    '{12'h048, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, 2'h2, 32'h0000_0000}
  };
  assign lines = {pwm_reset, converter0_reset, hibernation_reset, watchdog_reset, comparator_reset,
                  gp_counter_reset, two_wire_reset, quad_decoder_reset, sync_serial_reset,
                  async_serial_reset};
  psr_reset_ctrl psr_reset_ctrl_inst (
    .clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .capability_mask_one, .capability_mask_two, .pwm_reset, .converter0_reset, .hibernation_reset,
    .watchdog_reset, .comparator_reset, .gp_counter_reset, .two_wire_reset, .quad_decoder_reset,
    .sync_serial_reset, .async_serial_reset
  );
  psr_periph_model psr_periph_model_inst (.clock, .reset_lines(lines), .held_ff);
  // expected reset lines from expected register contents
  function automatic logic [19:0] expect_lines(input logic [31:0] lo, input logic [31:0] hi);
    return {lo[20], lo[16], lo[6], lo[3], hi[26:24], hi[19:16], hi[14], hi[12], hi[9:8],
            hi[5:4], hi[2:0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one write; stall delays bready to hold the answer up
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input int stall, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= (stall == 0);
    while (1) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clock);
      n++;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
      if (n >= stall) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask
  // one read; stall delays rready the same way
  task automatic axi_read(input logic [11:0] a, input int stall, output logic [31:0] d,
                          output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= (stall == 0);
    while (1) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      n++;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) break;
      if (n >= stall) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // free-running clock
  initial begin
    forever #5 clock = ~clock;
  end
  // cut a hang short; the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  // main sequence
  initial begin
    lo_exp = 32'h0000_0000;
    hi_exp = 32'h0000_0000;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clock);
      capability_mask_one <= (rows[i].addr == psr_pkg::LOW_OFFSET) ? rows[i].cap : 32'hFFFF_FFFF;
      capability_mask_two <= (rows[i].addr == psr_pkg::HIGH_OFFSET) ? rows[i].cap : 32'hFFFF_FFFF;
      axi_write(rows[i].addr, rows[i].data, rows[i].strb, i % 3, rsp);
      check(rsp, rows[i].resp);
      axi_read(rows[i].addr, i % 3, rd_data, rsp);
      check(rd_data, rows[i].rd);
      check(rsp, rows[i].resp);
      if (rows[i].addr == psr_pkg::LOW_OFFSET) lo_exp = rows[i].rd;
      if (rows[i].addr == psr_pkg::HIGH_OFFSET) hi_exp = rows[i].rd;
      check(held_ff, expect_lines(lo_exp, hi_exp));
    end
    // software sets one more field, keeping the rest as read
    axi_read(psr_pkg::LOW_OFFSET, 0, rd_data, rsp);
    axi_write(psr_pkg::LOW_OFFSET, rd_data | 32'h0000_0008, 4'hF, 0, rsp);
    axi_read(psr_pkg::LOW_OFFSET, 0, rd_data, rsp);
    check(rd_data, 32'h0001_0008);
    // a reset in mid-run clears both registers and every line
    axi_write(psr_pkg::HIGH_OFFSET, 32'hFFFF_FFFF, 4'hF, 1, rsp);
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    axi_read(psr_pkg::LOW_OFFSET, 0, rd_data, rsp);
    check(rd_data, psr_pkg::RESET_VALUE);
    axi_read(psr_pkg::HIGH_OFFSET, 0, rd_data, rsp);
    check(rd_data, psr_pkg::RESET_VALUE);
    check(held_ff, 20'h00000);
    finish_test();
  end
endmodule

/* psr_reset_drive.sv */
// registered output stage from register bits to peripheral reset lines
module psr_reset_drive (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register contents
  psr_reg_if.watch bus,
  // peripheral reset lines, active high
  output logic [31:0] lines
);

  logic [31:0] lines_ff; // flopped so the lines are glitch free

  // system reset also asserts nothing here; the peripherals
  // get the system reset on their own path
  always_ff @(posedge clock) begin
    if (reset) begin
      lines_ff <= psr_pkg::RESET_VALUE;
    end else begin
      lines_ff <= bus.value;
    end
  end

  assign lines = lines_ff;

endmodule

/* psr_reset_reg.sv */
// one software reset register with capability and field masking
module psr_reset_reg #(
  parameter logic [31:0] FIELD_MASK = 32'h0000_0000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register access
  psr_reg_if.regs bus
);

  logic [31:0] value_ff; // stored reset bits
  logic [31:0] wr_mask; // bits this write may change
  logic [31:0] nxt_value;

  // byte enables widened, then limited to fields of present units
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{bus.wr_strb[i]}};
    end
    // absent units and reserved bits never change
    wr_mask = wr_mask & FIELD_MASK & bus.cap_mask;
    nxt_value = (value_ff & ~wr_mask) | (bus.wr_data & wr_mask);
  end

  // storage; cleared on system reset
  always_ff @(posedge clock) begin
    if (reset) begin
      value_ff <= psr_pkg::RESET_VALUE;
    end else if (bus.wr_stb) begin
      value_ff <= nxt_value;
    end
  end

  assign bus.value = value_ff;

endmodule
